// >>> hw/svc_lamp_map.svh
// Purpose: Constants for the service port and status lamp block
// Assumes: 250 MHz mclk
// Notes: Times kept in their own units, cycle counts derived from them
`ifndef SVC_LAMP_MAP_SVH
`define SVC_LAMP_MAP_SVH
`define CLK_HZ 250000000
`define BAUD_RATE 9600
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)
`define LAMP_TEST_MS 500
`define LAMP_TEST_CYC ((`CLK_HZ / 1000) * `LAMP_TEST_MS)
`define GOOD_READ_MS 500
`define GOOD_READ_CYC ((`CLK_HZ / 1000) * `GOOD_READ_MS)
`define WARM_MIN_MS 200
`define WARM_MIN_CYC ((`CLK_HZ / 1000) * `WARM_MIN_MS)
`define COLD_MS 4000
`define COLD_CYC ((`CLK_HZ / 1000) * `COLD_MS)
`define BLINK_MS 250
`define BLINK_CYC ((`CLK_HZ / 1000) * `BLINK_MS)
`define CHR_STX 8'h02
`define CHR_CR 8'h0D
`define CHR_LF 8'h0A
`define LEARN_MAX 4'h8
`define MODE_SERVICE 1'b1
`endif

// >>> hw/svc_lamp_pkg.sv
// Purpose: Types shared by the service port and lamp block
// Assumes: Nothing beyond the map header
// Notes: Types only; numbers live in the map header
package svc_lamp_pkg;
    typedef struct packed {
        logic ready;
        logic fault;
        logic laser;
        logic good_read;
    } lamps_t;

    typedef struct packed {
        logic [7:0] code_type;
        logic [7:0] char_count;
        logic [3:0] label_count;
        logic trig_idle;
    } learn_set_t;

    typedef enum logic [1:0] {
        RX_HUNT = 2'b00,
        RX_BODY = 2'b01,
        RX_GOTCR = 2'b11
    } frame_st_t;

    typedef enum logic [1:0] {
        BTN_IDLE = 2'b00,
        BTN_PRESS = 2'b01,
        BTN_COLD = 2'b11
    } btn_st_t;
endpackage

// >>> hw/byte_buf2.sv
// Purpose: Two-entry byte buffer with valid and ready on both sides
// Assumes: Single clock
// Notes: Stalls upstream when both entries are held
`timescale 1ns/1ps
`include "svc_lamp_map.svh"
module byte_buf2
    import svc_lamp_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic mclk, // Clock
    input wire logic nrst, // Async reset, active low
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    input wire logic [WIDTH-1:0] in_data, // Word in
    output logic out_valid, // Word available
    input wire logic out_ready, // Drain accepts
    output logic [WIDTH-1:0] out_data // Word out, registered
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic [1:0] cnt;
    } buf_st_t;

    buf_st_t st_ff;
    buf_st_t nxt_st;
    logic push;
    logic pop;

    assign in_ready = (st_ff.cnt != 2'h2);
    assign out_valid = (st_ff.cnt != 2'h0);
    assign out_data = st_ff.mem[0];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Entry 0 is always the head; pop shifts entry 1 down
    always_comb begin
        nxt_st = st_ff;
        if (pop) begin
            nxt_st.mem[0] = st_ff.mem[1];
        end
        if (push) begin
            if (pop) begin
                nxt_st.mem[st_ff.cnt - 2'h1] = in_data;
            end else begin
                nxt_st.mem[st_ff.cnt[0]] = in_data;
            end
        end
        nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

// >>> hw/svc_lamp_ctrl.sv
// Purpose: Service port, learning mode control and status lamps
// Assumes: All inputs synchronous to mclk; UART lines idle high
// Notes: Behaviour
// Behaviour
// - Service switch cuts host, enables service port
// - Service port 9600 8N1 fixed
// - Frames are STX, payload, CR LF
// - Only TX/RX lines, no flow control
// - Operation mode: monitor scanner or host data
// - DIP switch two on/off enters and leaves learning mode
// - Learn on/off commands from either port
// - Ready and fault alternate while learning
// - Report code type, count, characters per label
// - Learn label count, capped at eight
// - Learn code type and character count
// - Trigger level while learning becomes idle level
// - Leaving learning stores and activates parameters
// - All lamps lit half second after power
// - Cold start holds all lamps until release
// - Link loss blinks all lamps together
// - Ready blinks in self test, then steady
// - Fault lamp for hardware error after self test, or serious error
// - Laser lamp follows laser operation
// - Laser lamp blinks on quality warning
// - Good read lamp half second per decode
// - Short press warm start, long press cold
// - Quality monitor warns below set share
`timescale 1ns/1ps
`include "svc_lamp_map.svh"
module svc_lamp_ctrl
    import svc_lamp_pkg::*;
#(
    parameter int BIT_CYC = `BIT_CYCLES,
    parameter int LAMP_TEST_CYC = `LAMP_TEST_CYC,
    parameter int GOOD_READ_CYC = `GOOD_READ_CYC,
    parameter int WARM_MIN_CYC = `WARM_MIN_CYC,
    parameter int COLD_CYC = `COLD_CYC,
    parameter int BLINK_CYC = `BLINK_CYC
) (
    input wire logic mclk, // 250 MHz clock
    input wire logic nrst, // Async reset, active low
    input wire logic mode_switch, // 1 service, 0 operation
    input wire logic monitor_sel_host, // Jumper: 1 host, 0 scanner
    input wire logic learn_dip, // DIP switch two
    input wire logic svc_rxd, // Service serial receive
    output logic svc_txd, // Service serial transmit
    input wire logic host_rx_line, // Host receive line, for monitor
    input wire logic scan_tx_line, // Scanner transmit line, for monitor
    output logic host_link_en, // Host link connected
    input wire logic host_learn_on, // Host learn-on pulse
    input wire logic host_learn_off, // Host learn-off pulse
    input wire logic tx_valid, // Payload byte offered
    output logic tx_ready, // Payload byte taken
    input wire logic [7:0] tx_data, // Payload byte
    input wire logic tx_end, // Last byte of frame
    output logic [7:0] rx_data, // Received payload byte
    output logic rx_valid, // Pulse per payload byte
    output logic rx_frame_done, // Pulse after CR LF
    input wire logic [7:0] cmd_learn_on, // Learn-on byte
    input wire logic [7:0] cmd_learn_off, // Learn-off byte
    output logic label_learning_mode, // Learning active
    input wire logic decode_ok, // Pulse: successful decode
    input wire learn_set_t decode_info, // Type and length of that decode
    output logic report_req, // Pulse: send learning report
    output learn_set_t learned_set, // Learned parameters
    output logic store_pulse, // Pulse: store and activate
    input wire logic trigger_input, // First switched trigger input
    input wire logic reset_button, // Reset button pressed
    output logic warm_start, // Pulse: warm start
    output logic cold_start, // Pulse: cold start
    input wire logic link_lost, // Scanner link lost
    input wire logic init_done, // Self test finished
    input wire logic hw_error, // Hardware error
    input wire logic sw_error, // Serious software error
    input wire logic laser_active, // Laser running
    input wire logic monitor_en, // Quality monitor enabled
    input wire logic scan_tick, // Pulse per scan
    input wire logic [6:0] min_percent, // Warning threshold percent
    output logic quality_warn, // Quality warning, registered
    output lamps_t lamps // Lamp drives
);
    // ************
    // State
    // ************
    typedef struct packed {
        frame_st_t rx_st;
        logic [15:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [8:0] rx_sh;
        logic rx_busy;
        logic [7:0] rx_byte;
        logic rx_valid;
        logic rx_done;
        logic [15:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
        logic tx_busy;
        logic [1:0] tx_tail;
        logic tx_head;
        logic learn;
        logic learn_dip_q;
        learn_set_t set;
        logic [3:0] run;
        logic store;
        logic report;
        logic [27:0] test_cnt;
        logic [27:0] gr_cnt;
        logic [31:0] btn_cnt;
        btn_st_t btn_st;
        logic warm;
        logic cold;
        logic [27:0] blink_cnt;
        logic blink;
        logic [15:0] scans;
        logic [15:0] hits;
        logic warn;
    } st_t;

    st_t st_ff;
    st_t nxt_st;
    logic buf_valid;
    logic buf_ready;
    logic [8:0] buf_data;

    // Frame payload waits here so a busy line never drops a byte
    byte_buf2 #(.WIDTH(9)) u_txbuf (
        .mclk(mclk),
        .nrst(nrst),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data({tx_end, tx_data}),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    function automatic logic [9:0] frame_char(input logic [7:0] b);
        frame_char = {1'b1, b, 1'b0}; // 8N1: stop, data LSB first, start
    endfunction

    wire svc_mode = (mode_switch == `MODE_SERVICE);
    assign buf_ready = svc_mode && !st_ff.tx_busy && st_ff.tx_head && (st_ff.tx_tail == 2'h0);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rx_valid = 1'b0;
        nxt_st.rx_done = 1'b0;
        nxt_st.store = 1'b0;
        nxt_st.report = 1'b0;
        nxt_st.warm = 1'b0;
        nxt_st.cold = 1'b0;
        // ************
        // Service receiver, 8N1, no handshake lines
        // ************
        if (!svc_mode) begin
            nxt_st.rx_busy = 1'b0;
            nxt_st.rx_st = RX_HUNT;
        end else if (!st_ff.rx_busy) begin
            if (!svc_rxd) begin
                nxt_st.rx_busy = 1'b1;
                nxt_st.rx_cnt = 16'(BIT_CYC / 2);
                nxt_st.rx_bit = 4'h0;
            end
        end else if (st_ff.rx_cnt != 16'h0) begin
            nxt_st.rx_cnt = st_ff.rx_cnt - 16'h1;
        end else begin
            nxt_st.rx_cnt = 16'(BIT_CYC - 1);
            nxt_st.rx_sh = {svc_rxd, st_ff.rx_sh[8:1]};
            nxt_st.rx_bit = st_ff.rx_bit + 4'h1;
            if (st_ff.rx_bit == 4'h9) begin
                nxt_st.rx_busy = 1'b0;
                // Sample 9 is the stop bit; a low stop is a framing error, byte dropped
                if (svc_rxd) begin
                    unique case (st_ff.rx_st)
                        RX_HUNT: if (st_ff.rx_sh[8:1] == `CHR_STX) nxt_st.rx_st = RX_BODY;
                        RX_BODY: begin
                            if (st_ff.rx_sh[8:1] == `CHR_CR) begin
                                nxt_st.rx_st = RX_GOTCR;
                            end else begin
                                nxt_st.rx_byte = st_ff.rx_sh[8:1];
                                nxt_st.rx_valid = 1'b1;
                            end
                        end
                        RX_GOTCR: begin
                            nxt_st.rx_st = RX_HUNT;
                            // CR without LF: frame abandoned
                            nxt_st.rx_done = (st_ff.rx_sh[8:1] == `CHR_LF);
                        end
                    endcase
                end
            end
        end
        // ************
        // Service transmitter: STX, payload, CR LF
        // ************
        if (st_ff.tx_busy) begin
            if (st_ff.tx_cnt != 16'h0) begin
                nxt_st.tx_cnt = st_ff.tx_cnt - 16'h1;
            end else begin
                nxt_st.tx_cnt = 16'(BIT_CYC - 1);
                nxt_st.tx_sh = {1'b1, st_ff.tx_sh[9:1]};
                nxt_st.tx_bit = st_ff.tx_bit + 4'h1;
                if (st_ff.tx_bit == 4'h9) nxt_st.tx_busy = 1'b0;
            end
        end else if (svc_mode) begin
            if (st_ff.tx_tail != 2'h0) begin
                nxt_st.tx_sh = frame_char(st_ff.tx_tail == 2'h2 ? `CHR_CR : `CHR_LF);
                nxt_st.tx_tail = st_ff.tx_tail == 2'h2 ? 2'h1 : 2'h0;
                nxt_st.tx_busy = 1'b1;
            end else if (!st_ff.tx_head && buf_valid) begin
                nxt_st.tx_sh = frame_char(`CHR_STX);
                nxt_st.tx_head = 1'b1;
                nxt_st.tx_busy = 1'b1;
            end else if (buf_valid) begin
                nxt_st.tx_sh = frame_char(buf_data[7:0]);
                nxt_st.tx_busy = 1'b1;
                if (buf_data[8]) begin
                    nxt_st.tx_head = 1'b0;
                    nxt_st.tx_tail = 2'h2;
                end
            end
            nxt_st.tx_cnt = 16'(BIT_CYC - 1);
            nxt_st.tx_bit = 4'h0;
        end
        // ************
        // Label learning
        // ************
        nxt_st.learn_dip_q = learn_dip;
        if ((learn_dip && !st_ff.learn_dip_q) || host_learn_on ||
            (st_ff.rx_valid && st_ff.rx_byte == cmd_learn_on)) begin
            nxt_st.learn = 1'b1;
        end
        if ((!learn_dip && st_ff.learn_dip_q) || host_learn_off ||
            (st_ff.rx_valid && st_ff.rx_byte == cmd_learn_off)) begin
            nxt_st.learn = 1'b0;
        end
        if (!st_ff.learn && nxt_st.learn) begin
            nxt_st.run = 4'h0;
            nxt_st.set.label_count = 4'h0;
        end
        if (st_ff.learn) begin
            nxt_st.set.trig_idle = trigger_input;
            if (decode_ok) begin
                nxt_st.report = 1'b1;
                nxt_st.set.code_type = decode_info.code_type;
                nxt_st.set.char_count = decode_info.char_count;
                if (st_ff.run != `LEARN_MAX) nxt_st.run = st_ff.run + 4'h1;
                if (nxt_st.run > st_ff.set.label_count) nxt_st.set.label_count = nxt_st.run;
            end else if (scan_tick) begin
                nxt_st.run = 4'h0; // Empty scan ends the row
            end
            if (!nxt_st.learn) nxt_st.store = 1'b1;
        end
        // ************
        // Reset button, lamp timers, quality monitor
        // ************
        if (st_ff.test_cnt != 28'h0) nxt_st.test_cnt = st_ff.test_cnt - 28'h1;
        if (decode_ok) begin
            nxt_st.gr_cnt = 28'(GOOD_READ_CYC);
        end else if (st_ff.gr_cnt != 28'h0) begin
            nxt_st.gr_cnt = st_ff.gr_cnt - 28'h1;
        end
        unique case (st_ff.btn_st)
            BTN_IDLE: begin
                nxt_st.btn_cnt = 32'h0;
                if (reset_button) nxt_st.btn_st = BTN_PRESS;
            end
            BTN_PRESS: begin
                nxt_st.btn_cnt = st_ff.btn_cnt + 32'h1;
                if (!reset_button) begin
                    nxt_st.btn_st = BTN_IDLE;
                    nxt_st.warm = (st_ff.btn_cnt >= 32'(WARM_MIN_CYC));
                end else if (st_ff.btn_cnt >= 32'(COLD_CYC)) begin
                    nxt_st.btn_st = BTN_COLD;
                    nxt_st.cold = 1'b1;
                end
            end
            BTN_COLD: if (!reset_button) nxt_st.btn_st = BTN_IDLE;
            default: nxt_st.btn_st = BTN_IDLE;
        endcase
        if (st_ff.blink_cnt == 28'h0) begin
            nxt_st.blink_cnt = 28'(BLINK_CYC - 1);
            nxt_st.blink = !st_ff.blink;
        end else begin
            nxt_st.blink_cnt = st_ff.blink_cnt - 28'h1;
        end
        if (!monitor_en) begin
            nxt_st.scans = 16'h0;
            nxt_st.hits = 16'h0;
            nxt_st.warn = 1'b0;
        end else if (scan_tick) begin
            // Window of 100 scans: hits in it equal the decoded percent
            nxt_st.scans = st_ff.scans + 16'h1;
            nxt_st.hits = st_ff.hits + {15'h0, decode_ok};
            if (st_ff.scans == 16'h63) begin
                nxt_st.warn = (nxt_st.hits < {9'h0, min_percent});
                nxt_st.scans = 16'h0;
                nxt_st.hits = 16'h0;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
            st_ff.tx_sh <= 10'h3FF;
            st_ff.test_cnt <= 28'(LAMP_TEST_CYC);
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************
    // Outputs
    // ************
    // Operation mode: connector echoes one of the passing lines
    assign svc_txd = svc_mode ? st_ff.tx_sh[0] :
        (monitor_sel_host ? host_rx_line : scan_tx_line);
    assign host_link_en = !svc_mode;
    assign rx_data = st_ff.rx_byte;
    assign rx_valid = st_ff.rx_valid;
    assign rx_frame_done = st_ff.rx_done;
    assign label_learning_mode = st_ff.learn;
    assign report_req = st_ff.report;
    assign learned_set = st_ff.set;
    assign store_pulse = st_ff.store;
    assign warm_start = st_ff.warm;
    assign cold_start = st_ff.cold;
    assign quality_warn = st_ff.warn;

    // Priority: test and cold start, link loss, learning, normal
    always_comb begin
        lamps = '0;
        if (st_ff.test_cnt != 28'h0 || st_ff.btn_st == BTN_COLD) begin
            lamps = '1;
        end else if (link_lost) begin
            lamps = {4{st_ff.blink}};
        end else if (st_ff.learn) begin
            lamps.ready = st_ff.blink;
            lamps.fault = !st_ff.blink;
        end else begin
            lamps.ready = init_done ? 1'b1 : st_ff.blink;
            lamps.fault = (hw_error && init_done) || sw_error;
        end
        if (st_ff.test_cnt == 28'h0 && st_ff.btn_st != BTN_COLD && !link_lost) begin
            lamps.laser = st_ff.warn ? st_ff.blink : laser_active;
            lamps.good_read = (st_ff.gr_cnt != 28'h0);
        end
    end
endmodule

// >>> dv/svc_lamp_checker.sv
// Purpose: Port assertions for the service port and lamp block
// Assumes: One clock domain, reset active low
// Notes: Bound to svc_lamp_ctrl by the bind below
`timescale 1ns/1ps
module svc_lamp_checker
    import svc_lamp_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic nrst, // Reset
    input wire logic mode_switch, // Mode
    input wire logic monitor_sel_host, // Jumper
    input wire logic host_rx_line, // Host line
    input wire logic scan_tx_line, // Scanner line
    input wire logic svc_txd, // Service out
    input wire logic host_link_en, // Host link
    input wire logic decode_ok, // Decode pulse
    input wire logic label_learning_mode, // Learning
    input wire logic report_req, // Report pulse
    input wire logic store_pulse, // Store pulse
    input wire learn_set_t learned_set, // Learned set
    input wire logic link_lost, // Link loss
    input wire logic hw_error, // Hardware error
    input wire logic sw_error, // Software error
    input wire logic reset_button, // Button
    input wire logic warm_start, // Warm pulse
    input wire logic cold_start, // Cold pulse
    input wire lamps_t lamps // Lamps
);
    // ************
    // Port relations
    // ************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    host_cut_a: assert property (host_link_en == !mode_switch)
        else $error("host link enable wrong for mode");
    monitor_echo_a: assert property (!mode_switch |->
        svc_txd == (monitor_sel_host ? host_rx_line : scan_tx_line))
        else $error("monitor echo wrong source");
    report_each_a: assert property (decode_ok && label_learning_mode |=> report_req)
        else $error("no report after decode");
    store_on_exit_a: assert property ($fell(label_learning_mode) |-> ##[0:1] store_pulse)
        else $error("no store on leaving learning");
    label_cap_a: assert property (learned_set.label_count <= 4'h8)
        else $error("label count above eight");
    // Three cycles of loss allow a registered input
    link_blink_a: assert property (link_lost && $past(link_lost) && $past(link_lost, 2)
        |-> (lamps == 4'hF) || (lamps == 4'h0))
        else $error("lamps not blinking together");
    learn_alt_a: assert property (label_learning_mode && $past(label_learning_mode)
        && !link_lost && !$past(link_lost) && !$past(link_lost, 2) && !hw_error
        && !sw_error && !reset_button |-> lamps.ready != lamps.fault)
        else $error("ready and fault not alternating");
    cold_lamps_a: assert property (cold_start |-> ##[0:1] (lamps == 4'hF))
        else $error("lamps not all lit on cold start");
    warm_release_a: assert property (warm_start |-> !reset_button && !cold_start)
        else $error("warm start while held");
endmodule
bind svc_lamp_ctrl svc_lamp_checker chk_i (.mclk, .nrst, .mode_switch, .monitor_sel_host,
    .host_rx_line, .scan_tx_line, .svc_txd, .host_link_en, .decode_ok, .label_learning_mode,
    .report_req, .store_pulse, .learned_set, .link_lost, .hw_error, .sw_error, .reset_button,
    .warm_start, .cold_start, .lamps);

// >>> dv/svc_terminal.sv
// Purpose: Terminal model on the service serial port
// Assumes: Bit time of BIT_CYC clocks, line idles high
// Notes: No handshake lines exist, only receive and transmit
`timescale 1ns/1ps
module svc_terminal #(
    parameter int BIT_CYC = 8
) (
    input wire logic mclk, // Clock
    input wire logic line_in, // Device transmit line
    output logic line_out // Device receive line
);
    logic [7:0] got[$];
    logic [7:0] sh;

    initial line_out = 1'b1;

    // One 8N1 character, LSB first, idle high afterwards
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 10; i++) begin
            line_out <= (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : b[i-1]);
            repeat (BIT_CYC) @(posedge mclk);
        end
    endtask

    // Whole frame: start byte, one payload byte, CR, LF
    task automatic send_frame(input logic [7:0] b);
        send(8'h02);
        send(b);
        send(8'h0D);
        send(8'h0A);
    endtask

    // Receiver samples mid-bit; a bad stop bit drops the character
    initial begin
        forever begin
            @(negedge line_in);
            repeat (BIT_CYC / 2) @(posedge mclk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge mclk);
                sh[i] = line_in;
            end
            repeat (BIT_CYC) @(posedge mclk);
            if (line_in === 1'b1) got.push_back(sh);
        end
    end
endmodule

// >>> dv/svc_lamp_ctrl_tb_top.sv
// Purpose: Directed tests of the service port and lamp block
// Assumes: Shortened counts set by parameters below
// Notes: Inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ps
module svc_lamp_ctrl_tb_top
    import svc_lamp_pkg::*;
;
    logic mclk, nrst, mode_switch, monitor_sel_host, learn_dip, svc_rxd, svc_txd;
    logic host_rx_line, scan_tx_line, host_link_en, host_learn_on, host_learn_off;
    logic tx_valid, tx_ready, tx_end, rx_valid, rx_frame_done, label_learning_mode;
    logic decode_ok, report_req, store_pulse, trigger_input, reset_button, warm_start;
    logic cold_start, link_lost, init_done, hw_error, sw_error, laser_active;
    logic monitor_en, scan_tick, quality_warn;
    logic [7:0] tx_data, rx_data, cmd_learn_on, cmd_learn_off, last_rx;
    logic [6:0] min_percent;
    learn_set_t decode_info, learned_set;
    lamps_t lamps, l0;
    logic [7:0] exp_tx [5] = '{8'h02, 8'h41, 8'h42, 8'h0D, 8'h0A};
    int miscompares = 0, check_count = 0, n_rx = 0, n_done = 0, n_rep = 0, n_store = 0;
    int n_warm = 0, n_cold = 0;

    svc_lamp_ctrl #(.BIT_CYC(8), .LAMP_TEST_CYC(20), .GOOD_READ_CYC(20), .WARM_MIN_CYC(10),
        .COLD_CYC(50), .BLINK_CYC(4)) dut (.*);
    svc_terminal #(.BIT_CYC(8)) term (.mclk(mclk), .line_in(svc_txd), .line_out(svc_rxd));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Event counters for the registered pulses
    always @(posedge mclk) begin
        if (rx_valid === 1'b1) n_rx++;
        if (rx_valid === 1'b1) last_rx = rx_data;
        if (rx_frame_done === 1'b1) n_done++;
        if (report_req === 1'b1) n_rep++;
        if (store_pulse === 1'b1) n_store++;
        if (warm_start === 1'b1) n_warm++;
        if (cold_start === 1'b1) n_cold++;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Offer a payload byte and hold it until an edge sees ready
    task automatic push(input logic [7:0] b, input logic e);
        int k;
        k = 0;
        tx_valid <= 1'b1;
        tx_data <= b;
        tx_end <= e;
        do begin
            tick(1);
            k++;
        end while (tx_ready !== 1'b1 && k < 1000);
    endtask

    task automatic decode(input int n);
        repeat (n) begin
            decode_ok <= 1'b1;
            tick(1);
            decode_ok <= 1'b0;
            tick(2);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ************
    // Main sequence
    // ************
    initial begin
        {nrst, mode_switch, monitor_sel_host, learn_dip, host_learn_on, host_learn_off} = '0;
        {tx_valid, tx_end, decode_ok, trigger_input, reset_button, link_lost} = '0;
        {init_done, hw_error, sw_error, laser_active, monitor_en, scan_tick} = '0;
        {host_rx_line, scan_tx_line} = 2'h3;
        tx_data = 8'h00;
        cmd_learn_on = 8'h2B;
        cmd_learn_off = 8'h2D;
        min_percent = 7'h32;
        decode_info = {8'h11, 8'h0A, 5'h00};
        tick(20);
        nrst <= 1'b1;
        tick(2);
        chk("lamp test", lamps, 4'hF);
        tick(25);
        l0 = lamps;
        tick(4);
        chk("ready blink", l0.ready ^ lamps.ready, 1'b1);
        init_done <= 1'b1;
        laser_active <= 1'b1;
        tick(3);
        chk("ready laser", lamps, 4'hA);
        laser_active <= 1'b0;
        hw_error <= 1'b1;
        decode(1);
        chk("fault good", lamps, 4'hD);
        {hw_error, sw_error} <= 2'h1;
        tick(25);
        chk("good off", lamps, 4'hC);
        {mode_switch, sw_error} <= 2'h2;
        tick(2);
        chk("host cut", host_link_en, 1'b0);
        push(8'h41, 1'b0);
        push(8'h42, 1'b1);
        tx_valid <= 1'b0;
        for (int k = 0; k < 1000 && term.got.size() < 5; k++) tick(1);
        chk("tx frame", term.got.size(), 5);
        for (int i = 0; i < 5 && i < term.got.size(); i++)
            chk("tx byte", term.got[i], exp_tx[i]);
        term.send(8'h55);
        term.send_frame(8'h2B);
        tick(20);
        chk("rx count", n_rx, 1);
        chk("rx byte", last_rx, 8'h2B);
        chk("rx done", n_done, 1);
        chk("learn on", label_learning_mode, 1'b1);
        decode(10);
        chk("reports", n_rep, 10);
        term.send_frame(8'h2D);
        tick(20);
        chk("learn off", label_learning_mode, 1'b0);
        chk("store", n_store, 1);
        chk("learned", learned_set, {8'h11, 8'h0A, 4'h8, 1'b0});
        learn_dip <= 1'b1;
        trigger_input <= 1'b1;
        decode_info.code_type <= 8'h22;
        tick(3);
        chk("dip on", label_learning_mode, 1'b1);
        decode(3);
        scan_tick <= 1'b1;
        tick(1);
        scan_tick <= 1'b0;
        decode(2);
        learn_dip <= 1'b0;
        tick(4);
        chk("dip off", label_learning_mode, 1'b0);
        chk("relearn", learned_set, {8'h22, 8'h0A, 4'h3, 1'b1});
        host_learn_on <= 1'b1;
        tick(1);
        host_learn_on <= 1'b0;
        tick(3);
        chk("host on", label_learning_mode, 1'b1);
        host_learn_off <= 1'b1;
        tick(1);
        host_learn_off <= 1'b0;
        tick(3);
        chk("host off", label_learning_mode, 1'b0);
        reset_button <= 1'b1;
        tick(20);
        reset_button <= 1'b0;
        tick(3);
        chk("warm", n_warm, 1);
        reset_button <= 1'b1;
        tick(60);
        chk("cold", n_cold, 1);
        chk("cold lamps", lamps, 4'hF);
        reset_button <= 1'b0;
        tick(3);
        chk("no warm", n_warm, 1);
        link_lost <= 1'b1;
        tick(6);
        l0 = lamps;
        tick(4);
        chk("link blink", l0 ^ lamps, 4'hF);
        link_lost <= 1'b0;
        monitor_en <= 1'b1;
        repeat (101) begin
            scan_tick <= 1'b1;
            tick(1);
            scan_tick <= 1'b0;
            tick(1);
        end
        laser_active <= 1'b1;
        tick(3);
        chk("warn", quality_warn, 1'b1);
        l0 = lamps;
        tick(4);
        chk("laser blink", l0.laser ^ lamps.laser, 1'b1);
        mode_switch <= 1'b0;
        scan_tx_line <= 1'b0;
        tick(2);
        chk("echo scan", svc_txd, 1'b0);
        {monitor_sel_host, host_rx_line} <= 2'h2;
        tick(2);
        chk("echo host", svc_txd, 1'b0);
        final_report();
    end

    // Watchdog well beyond the test length
    initial begin
        tick(40000);
        miscompares++;
        final_report();
    end
endmodule
